/* hdl/sac_link_if.sv */
`timescale 1ns/1ns
// Event and data crossing from link domain to system clock domain
interface sac_link_if #(parameter int W = 14);
  logic done_tgl;
  logic [W-1:0] word;
  modport src (output done_tgl, output word);
  modport dst (input done_tgl, input word);
endinterface : sac_link_if

/* hdl/sac_pkg.sv */
// Function
// - After power-up the device is active and accepts a conversion start at once.
// - Two start edges with no serial clock edge between them enter nap.
// - Nap keeps the internal reference powered.
// - Serial clock edges wake from nap; next start converts accurately.
// - Four start edges with no serial clock edge between them enter sleep, reference off.
// - Serial clock edges wake from sleep; host waits 2 ms for reference settling.
// - Start edge begins conversion; later starts ignored until 16 clock edges pass.
// - Whole result stream leaves within first 16 clock periods after start; code sends the LSB on the 19th or 20th edge after start.
// - Any duty cycle on the start input is accepted.
// - Sample-and-hold goes from track to hold on the start rising edge; code holds from the accept edge, the third or fourth link edge after it.
// - Result is two's complement of positive minus negative input.
// - Result bits go out MSB first from the third clock edge after start; code counts from the accept edge, so the MSB is on the sixth or seventh.
// - Data output is high impedance at power-up and whenever not sending.
// - Device updates data on clock rising edge; host samples on falling edge.
package sac_pkg;
  localparam int RES_BITS = 14;
  localparam logic [4:0] FIRST_BIT_EDGE = 5'h03;
  localparam logic [4:0] REARM_EDGES = 5'h10;
  localparam logic [4:0] RELEASE_EDGES = 5'h11;
  localparam logic [2:0] NAP_STARTS = 3'h2;
  localparam logic [2:0] SLEEP_STARTS = 3'h4;
  localparam int REF_SETTLE_NS = 2000000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int REF_SETTLE_CYC = (REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SAC_ACTIVE = 2'b00,
    SAC_NAP = 2'b01,
    SAC_SLEEP = 2'b10
  } sac_power_e;
endpackage : sac_pkg

/* hdl/sac_sync.sv */
`timescale 1ns/1ns
// Two-flop synchroniser for a level
module sac_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic d,
  output logic q
);
  logic meta;

  // First flop feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : sac_sync

/* hdl/sac_top.sv */
`timescale 1ns/1ns
// Serial converter control: start detect, power-down, serial result shifter.
// Link logic runs on the serial clock; start edges are seen by the system clock
// after a two-flop synchroniser, so the start pin must stay steady >= 3 clk.
module sac_top #(
  parameter int RES_BITS = sac_pkg::RES_BITS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic serial_clock,
  input wire logic conversion_start,
  input wire logic [RES_BITS-1:0] sample_code,
  output logic serial_data_out,
  output logic serial_data_oe_n,
  output logic hold_sample,
  output logic reference_on,
  output logic core_on,
  output logic [1:0] power_state,
  output logic reference_settled,
  output logic result_valid,
  output logic [RES_BITS-1:0] result_word
);
  localparam int SETTLE_W = $clog2(sac_pkg::REF_SETTLE_CYC + 1);

  sac_link_if #(.W(RES_BITS)) lnk ();

  // Link domain: start sync into serial clock domain
  logic start_s;
  sac_sync u_start_sync (
    .clk(serial_clock),
    .arst_n(arst_n),
    .d(conversion_start),
    .q(start_s)
  );

  // Start edge as seen in clk domain, used for power-down counting
  logic start_c;
  logic start_c_d;
  logic start_rise;
  sac_sync u_start_csync (
    .clk(clk),
    .arst_n(arst_n),
    .d(conversion_start),
    .q(start_c)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      start_c_d <= 1'b0;
    end else begin
      start_c_d <= start_c;
    end
  end

  assign start_rise = start_c & !start_c_d;

  // Serial clock activity crossing into the clk domain. A lone toggle flop
  // would alias when two link edges land inside one clk period (the link may
  // run faster than clk), and a missed edge would leave the block asleep.
  // A small gray count is carried over instead: one bit moves per link edge,
  // so each clk sample is a legal code and any change means activity.
  // Limitation: a whole wrap of the count within one clk period aliases, so
  // the link may run at most seven edges per clk period.
  localparam int ACT_W = 3;
  logic [ACT_W-1:0] sck_bin;
  logic [ACT_W-1:0] next_sck_bin;
  logic [ACT_W-1:0] sck_gray;
  logic [ACT_W-1:0] sck_gray_s;
  logic [ACT_W-1:0] sck_gray_d;
  logic sck_seen;

  // Binary to gray, so that successive counts differ in one bit only
  function automatic logic [ACT_W-1:0] to_gray(input logic [ACT_W-1:0] b);
    return b ^ (b >> 1);
  endfunction : to_gray

  // Next link edge count; wraps freely, only a change is of interest
  assign next_sck_bin = sck_bin + ACT_W'(1);

  // Count and its gray image, both flops of the link domain
  always_ff @(posedge serial_clock or negedge arst_n) begin
    if (!arst_n) begin
      sck_bin <= '0;
      sck_gray <= '0;
    end else begin
      sck_bin <= next_sck_bin;
      sck_gray <= to_gray(next_sck_bin); // Registered so no glitch crosses
    end
  end

  // One synchroniser per gray bit; the first flops feed nothing else
  for (genvar i = 0; i < ACT_W; i++) begin : g_sck_sync
    sac_sync u_sck_sync (
      .clk(clk),
      .arst_n(arst_n),
      .d(sck_gray[i]),
      .q(sck_gray_s[i])
    );
  end

  // Previous synchronised code, for change detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_gray_d <= '0;
    end else begin
      sck_gray_d <= sck_gray_s;
    end
  end

  assign sck_seen = (sck_gray_s != sck_gray_d);

  // Consecutive start counter, cleared by any serial clock edge; saturates at four.
  // A clock edge seen in the same clk cycle as a start wins and clears the count,
  // so a start racing the last link edge of a frame is not counted toward nap.
  logic [2:0] start_run;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      start_run <= 3'h0;
    end else if (sck_seen) begin
      start_run <= 3'h0;
    end else if (start_rise && start_run != sac_pkg::SLEEP_STARTS) begin
      start_run <= start_run + 3'h1;
    end
  end

  // Power state: active after reset; clock edge wakes from either power-down
  sac_pkg::sac_power_e pstate;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pstate <= sac_pkg::SAC_ACTIVE;
    end else if (sck_seen) begin
      pstate <= sac_pkg::SAC_ACTIVE;
    end else if (start_rise && start_run == sac_pkg::SLEEP_STARTS - 3'h1) begin
      pstate <= sac_pkg::SAC_SLEEP;
    end else if (start_rise && start_run == sac_pkg::NAP_STARTS - 3'h1) begin
      pstate <= sac_pkg::SAC_NAP;
    end
  end

  assign power_state = pstate;
  assign core_on = (pstate == sac_pkg::SAC_ACTIVE);
  assign reference_on = (pstate != sac_pkg::SAC_SLEEP);

  // Reference settling timer after a sleep; the host must honour it
  logic [SETTLE_W-1:0] settle_cnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      settle_cnt <= '0;
    end else if (pstate == sac_pkg::SAC_SLEEP) begin
      settle_cnt <= SETTLE_W'(sac_pkg::REF_SETTLE_CYC);
    end else if (settle_cnt != '0) begin
      settle_cnt <= settle_cnt - 1'b1;
    end
  end

  assign reference_settled = (settle_cnt == '0);

  // Link domain conversion sequencer. Edges are numbered from the accept edge
  // (edge 0), which is the third or fourth link edge after the start pin rises,
  // because the pin is synchronised first:
  //   edge 0      busy rises, hold begins, the code is captured
  //   edges 1..2  nothing leaves the block
  //   edge 3      output enable falls, MSB driven
  //   edges 4..16 one bit further per edge, LSB on edge 16, busy falls
  //   edge 17     output released to high impedance
  // A start seen while busy is dropped, not queued; the host must space
  // starts 17 link edges apart for the next one to be taken.
  logic start_s_d;
  logic busy;
  logic [4:0] edge_cnt;
  logic [4:0] ncnt;
  logic [RES_BITS-1:0] shreg;
  logic accept;

  // Number of the link edge now being taken
  assign ncnt = edge_cnt + 5'h01;

  // Edges on which a bit is driven; the shifter moves on the same edges,
  // so each bit stands for exactly one link period
  function automatic logic in_bit_window(input logic [4:0] n);
    return (n >= sac_pkg::FIRST_BIT_EDGE)
           && (n < sac_pkg::FIRST_BIT_EDGE + 5'(RES_BITS));
  endfunction : in_bit_window

  always_ff @(posedge serial_clock or negedge arst_n) begin
    if (!arst_n) begin
      start_s_d <= 1'b0;
    end else begin
      start_s_d <= start_s;
    end
  end

  // Level-only edge detect: any duty cycle on the start line works
  assign accept = start_s & !start_s_d & !busy;

  always_ff @(posedge serial_clock or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      edge_cnt <= 5'h00;
    end else if (accept) begin
      busy <= 1'b1;
      edge_cnt <= 5'h00;
    end else if (busy) begin
      edge_cnt <= edge_cnt + 5'h01;
      if (edge_cnt + 5'h01 == sac_pkg::REARM_EDGES) begin
        busy <= 1'b0;
      end
    end
  end

  // Hold follows the accepted start until tracking resumes
  assign hold_sample = busy;

  // Result capture and MSB-first shifting; code arrives already two's complement
  always_ff @(posedge serial_clock or negedge arst_n) begin
    if (!arst_n) begin
      shreg <= '0;
    end else if (accept) begin
      shreg <= sample_code;
    end else if (busy && in_bit_window(ncnt)) begin
      shreg <= {shreg[RES_BITS-2:0], 1'b0};
    end
  end

  // Output stage: drive only while bits are being sent, within 16 periods
  // The shifter reads its top bit here before moving, so the MSB is not doubled
  always_ff @(posedge serial_clock or negedge arst_n) begin
    if (!arst_n) begin
      serial_data_out <= 1'b0;
      serial_data_oe_n <= 1'b1;
    end else if (busy && in_bit_window(ncnt)) begin
      serial_data_out <= shreg[RES_BITS-1];
      serial_data_oe_n <= 1'b0;
    end else begin
      serial_data_out <= 1'b0;
      serial_data_oe_n <= 1'b1;
    end
  end

  // Hand the captured word to the system side with a toggle
  logic done_tgl;
  logic [RES_BITS-1:0] word_hold;
  always_ff @(posedge serial_clock or negedge arst_n) begin
    if (!arst_n) begin
      done_tgl <= 1'b0;
      word_hold <= '0;
    end else if (accept) begin
      done_tgl <= !done_tgl;
      word_hold <= sample_code;
    end
  end

  assign lnk.done_tgl = done_tgl;
  assign lnk.word = word_hold;

  // Word is stable for a whole conversion, so the toggle qualifies it safely
  logic done_s;
  logic done_d;
  sac_sync u_done_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(lnk.done_tgl),
    .q(done_s)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_d <= 1'b0;
      result_valid <= 1'b0;
      result_word <= '0;
    end else begin
      done_d <= done_s;
      result_valid <= done_s ^ done_d;
      if (done_s ^ done_d) begin
        result_word <= lnk.word;
      end
    end
  end
endmodule : sac_top

/* verification/sac_host_model.sv */
`timescale 1ns/1ns
// Host: link clock runs only inside ticks calls (frames, reset, wake), bits taken on falling edges
module sac_host_model (
  output logic serial_clock,
  output logic conversion_start,
  input wire logic serial_data_out,
  input wire logic serial_data_oe_n
);
  logic [13:0] word;
  int nbits;
  initial {serial_clock, conversion_start} = 2'h0;
  task automatic ticks(input int n);
    repeat (n) begin
      #24 serial_clock = 1'h1;
      #24 if (!serial_data_oe_n) begin
        word = {word[12:0], serial_data_out};
        nbits++;
      end
      serial_clock = 1'h0;
    end
  endtask : ticks
  // A second start, when asked, lands while the device is busy
  task automatic frame(input logic again);
    word = 14'h0000;
    nbits = 0;
    conversion_start = 1'h1;
    ticks(4);
    conversion_start = 1'h0;
    ticks(4);
    conversion_start = again;
    ticks(4);
    conversion_start = 1'h0;
    ticks(12);
  endtask : frame
  // Held 400 ns so the slow domain sees every edge
  task automatic pulse();
    conversion_start = 1'h1;
    #400 conversion_start = 1'h0;
    #400;
  endtask : pulse
endmodule : sac_host_model

/* verification/sac_top_monitor.sv */
`timescale 1ns/1ns
module sac_top_monitor (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic serial_clock,
  input wire logic serial_data_out,
  input wire logic serial_data_oe_n,
  input wire logic hold_sample,
  input wire logic reference_on,
  input wire logic core_on,
  input wire logic [1:0] power_state,
  input wire logic reference_settled
);
  logic [4:0] lo_n;
  // Length of the drive window in link edges, too long for a repetition
  always_ff @(posedge serial_clock or negedge arst_n) begin
    if (!arst_n) lo_n <= 5'h00;
    else lo_n <= serial_data_oe_n ? 5'h00 : lo_n + 5'h01;
  end
  AST_IDLE: assert property (@(posedge serial_clock) disable iff (!arst_n)
    serial_data_oe_n |-> !serial_data_out) else $error("idle data");
  AST_LEN: assert property (@(posedge serial_clock) disable iff (!arst_n)
    $rose(serial_data_oe_n) |-> lo_n == 5'h0E) else $error("burst length");
  AST_FIRST: assert property (@(posedge serial_clock) disable iff (!arst_n)
    $rose(hold_sample) |-> serial_data_oe_n[*3] ##1 !serial_data_oe_n) else $error("first bit");
  AST_REL: assert property (@(posedge serial_clock) disable iff (!arst_n)
    $fell(hold_sample) |=> serial_data_oe_n) else $error("no release");
  AST_HOLD: assert property (@(posedge serial_clock) disable iff (!arst_n)
    !serial_data_oe_n |-> hold_sample || $past(hold_sample)) else $error("hold");
  AST_ACT: assert property (@(posedge clk) disable iff (!arst_n)
    power_state == 2'h0 |-> core_on && reference_on) else $error("active power");
  AST_NAP: assert property (@(posedge clk) disable iff (!arst_n)
    power_state == 2'h1 |-> reference_on && !core_on) else $error("nap power");
  AST_SLEEP: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(power_state[1]) |-> ##2 !reference_settled[*4]) else $error("settle");
endmodule : sac_top_monitor
bind sac_top sac_top_monitor sac_top_monitor_inst (.*);

/* verification/sac_top_test.sv */
`timescale 1ns/1ns
module sac_top_test;
  logic clk, arst_n, serial_clock, conversion_start, serial_data_out, serial_data_oe_n;
  logic hold_sample, reference_on, core_on, reference_settled, result_valid;
  logic [1:0] power_state;
  logic [13:0] sample_code, result_word, code;
  int num_errors = 0, checks_done = 0;
  logic [13:0] exp_q[$];
  wire [13:0] pins = 14'({power_state, reference_on, core_on});
  sac_top sac_top_inst (.*);
  sac_host_model sac_host_model_inst (.*);
  initial clk = 1'h0;
  always #50 clk = ~clk;
  task automatic cmp(input logic [13:0] got, input logic [13:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : cmp
  task automatic report_and_stop();
    $display("%0d errors in %0d checks", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // Each result pulse must carry the one code still owed, and only one
  always @(negedge clk) begin
    if (result_valid === 1'h1) begin
      cmp(14'(exp_q.size()), 14'h0001);
      if (exp_q.size() != 0) cmp(result_word, exp_q.pop_front());
    end
  end
  // Power pins after n unbroken starts: {state, ref on, core on}
  function automatic logic [13:0] pwr(input int n);
    return n >= 4 ? 14'h0008 : n >= 2 ? 14'h0006 : 14'h0003;
  endfunction : pwr
  // Code moves after the accepted start, so a resample would show
  task automatic convert(input logic again);
    @(negedge clk);
    code = 14'($urandom);
    sample_code = code;
    exp_q.push_back(code);
    fork
      sac_host_model_inst.frame(again);
      #300 sample_code = ~code;
    join
    cmp(sac_host_model_inst.word, code);
    cmp(14'(sac_host_model_inst.nbits), 14'h000E);
    cmp(result_word, code);
  endtask : convert
  task automatic power_seq(input int n);
    // Let the last link edges of the frame clear the crossing first
    repeat (4) @(negedge clk);
    for (int k = 1; k <= n; k++) begin
      @(negedge clk);
      sac_host_model_inst.pulse();
      cmp(pins, pwr(k));
    end
    sac_host_model_inst.ticks(2);
    repeat (20) if (power_state !== 2'h0) @(negedge clk);
    cmp(pins, pwr(0));
    if (power_state !== 2'h0) report_and_stop();
    if (n >= 4) cmp(14'(reference_settled), 14'h0000);
  endtask : power_seq
  // Reset with both clocks ticking, then conversions and power-down
  initial begin
    arst_n = 1'h0;
    sample_code = 14'h0000;
    void'($urandom(85810));
    sac_host_model_inst.ticks(3);
    repeat (16) @(negedge clk);
    arst_n = 1'h1;
    sac_host_model_inst.ticks(3);
    cmp(pins, pwr(0));
    cmp(14'(serial_data_oe_n), 14'h0001);
    for (int i = 0; i < 3; i++) convert(i[0]);
    power_seq(2);
    convert(1'h0);
    power_seq(4);  // Sleep entered only once in the run
    convert(1'h1);
    cmp(14'(exp_q.size()), 14'h0000);
    report_and_stop();
  end
endmodule : sac_top_test
